// ### inc/cec_cfg.svh
// constants of the control bus transmit slice and waveform checker
`ifndef CEC_CFG_SVH
`define CEC_CFG_SVH
// register byte offsets
`define OFS_RX_CTRL      8'h00
`define OFS_TX_ENABLE    8'h04
`define OFS_TX_BUFFER    8'h08
`define OFS_TX_TIMING    8'h0c
`define OFS_INT_STATUS   8'h10
`define OFS_INT_MASK     8'h14
// receive control fields
`define RXC_RX_EN        0
`define RXC_WAV_EN       1
`define RXC_WAV0_LSB     4
`define RXC_WAV1_LSB     8
`define RXC_WAV2_LSB     12
`define RXC_WAV3_LSB     16
`define RXC_MASK         32'h0007_7773
// transmit fields
`define TXE_GO           0
`define TXE_BUSY         1
`define TXB_EOM          8
`define TXB_MASK         32'h0000_01ff
`define TXT_MASK         32'h0077_7f1f
`define TXT_STRS_LSB     20
`define TXT_SPRD_LSB     16
`define TXT_DTRS_LSB     12
`define TXT_DPRD_LSB     8
// interrupt status bits
`define IRQ_TX_DONE      0
`define IRQ_WAV_ERR      1
`define IRQ_TX_ERR       2
`define IRQ_MASK         32'h0000_0007
// waveform base times in sampling periods
`define BASE_LATE_ZERO   8'd56
`define BASE_ONE_END     8'd26
`define BASE_ZERO_START  8'd43
`define BASE_EARLY_ONE   8'd13
// transmit base times in sampling periods
`define BASE_START_RISE  8'd121
`define BASE_START_CYC   8'd147
`define BASE_RISE_ONE    8'd20
`define BASE_RISE_ZERO   8'd49
`define BASE_DATA_CYC    8'd79
// sampling period in ns and system clock period in ns
`define SAMPLE_NS        30518
`define CLK_NS           10
`define SAMPLE_CYC       (`SAMPLE_NS / `CLK_NS)
`endif

// ### inc/cec_pkg.sv
// types of the control bus transmit slice
package cec_pkg;
	typedef enum logic [4:0] {
		TX_IDLE  = 5'b00001,
		TX_START = 5'b00010,
		TX_DATA  = 5'b00100,
		TX_ACK   = 5'b01000,
		TX_FREE  = 5'b10000
	} tx_state_t;
endpackage : cec_pkg

// ### verification/cec_ctrl_chk.sv
// bus handshake and line output checker
`timescale 1ns/1ps
module cec_ctrl_chk (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// line
	input wire logic        cec_out,
	input wire logic        cec_oe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid lost");
	a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid lost");
	a_w_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("no b");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("no r");
	a_b_single: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid) else $error("b twice");
	a_aw_refused: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready) else $error("aw taken");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("ar taken");
	a_line_drain: assert property (cec_out == 1'b0) else $error("out high");
	a_pull_length: assert property ($rose(cec_oe) |-> cec_oe [*8])
		else $error("short low");
endmodule : cec_ctrl_chk

bind cec_ctrl cec_ctrl_chk chk (
	.aclk          (aclk),
	.aresetn       (aresetn),
	.s_axi_awvalid (s_axi_awvalid),
	.s_axi_awready (s_axi_awready),
	.s_axi_wvalid  (s_axi_wvalid),
	.s_axi_wready  (s_axi_wready),
	.s_axi_bresp   (s_axi_bresp),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_bready  (s_axi_bready),
	.s_axi_arvalid (s_axi_arvalid),
	.s_axi_arready (s_axi_arready),
	.s_axi_rdata   (s_axi_rdata),
	.s_axi_rvalid  (s_axi_rvalid),
	.s_axi_rready  (s_axi_rready),
	.cec_out       (cec_out),
	.cec_oe        (cec_oe)
);

// ### verification/cec_node.sv
// far node on the shared line
`timescale 1ns/1ps
module cec_node (
	// clock
	input wire logic aclk,
	// line
	input wire logic dut_oe,
	output logic     line
);
	logic pull_ff = 1'b0;
	// wired-and with pull-up
	assign line = !(dut_oe || pull_ff);
	task send_bit(input int lo, input int hi);
		pull_ff <= 1'b1;
		repeat (lo) @(posedge aclk);
		pull_ff <= 1'b0;
		repeat (hi) @(posedge aclk);
	endtask : send_bit
endmodule : cec_node

// ### verification/test_cec_ctrl.sv
// self-checking bench of the control bus slice
`timescale 1ns/1ps
`include "cec_cfg.svh"
module test_cec_ctrl;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, v;
	logic [31:0] lfsr = 32'h7b12f886;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        cec_in, cec_out, cec_oe, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [8:0]  got;
	logic        err_exp;
	int          miscompares = 0, n_tests = 0, cyc = 0, cnt = 0;
	int          lows[$];
	int          lo[10] = '{20, 48, 8, 34, 62, 62, 9, 60, 30, 39};
	logic [31:0] cf[10] = '{32'h3, 32'h3, 32'h3, 32'h3, 32'h3, 32'h1,
		32'h73, 32'h70003, 32'h703, 32'h7003};
	logic [7:0]  ad[4] = '{`OFS_TX_BUFFER, `OFS_TX_TIMING, `OFS_RX_CTRL,
		`OFS_INT_MASK};
	logic [31:0] mk[4] = '{`TXB_MASK, `TXT_MASK, `RXC_MASK, `IRQ_MASK};

	cec_ctrl #(.SAMPLE_DIV(4)) dut (.*);
	cec_node node (.aclk(aclk), .dut_oe(cec_oe), .line(cec_in));

	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			miscompares++;
			test_done();
		end
	end
	// low pulse lengths driven by the design, in clock cycles
	always @(posedge aclk)
		if (cec_oe)
			cnt <= cnt + 1;
		else if (cnt != 0) begin
			lows.push_back(cnt);
			cnt <= 0;
		end

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd
	function automatic logic exp_err(input int t, input logic [31:0] c);
		if (!c[`RXC_RX_EN] || !c[`RXC_WAV_EN])
			return 1'b0;
		return t < `BASE_EARLY_ONE - c[6:4] || t > `BASE_LATE_ZERO + c[18:16]
			|| (t > `BASE_ONE_END + c[10:8] && t < `BASE_ZERO_START - c[14:12]);
	endfunction : exp_err
	task cmp_word(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp_word
	task wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= x;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task wait_busy(input logic b);
		do
			rd(`OFS_TX_ENABLE);
		while (d[`TXE_BUSY] !== b);
	endtask : wait_busy
	task test_done();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 28; i += 4) begin
			rd(8'(i));
			cmp_word(d, 32'h0);
			cmp_word({30'h0, r}, i == 24 ? 32'h2 : 32'h0);
		end
		wr(8'h18, rnd());
		cmp_word({30'h0, r}, 32'h2);
		for (int i = 0; i < 12; i++) begin
			v = rnd();
			wr(ad[i % 4], v);
			rd(ad[i % 4]);
			cmp_word(d, v & mk[i % 4]);
		end
		wr(`OFS_TX_ENABLE, 32'h2);
		rd(`OFS_TX_ENABLE);
		cmp_word(d, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 10; i++) begin
			wr(`OFS_RX_CTRL, 32'h0);
			rd(`OFS_RX_CTRL);
			cmp_word(d, 32'h0);
			wr(`OFS_RX_CTRL, cf[i]);
			wr(`OFS_INT_MASK, 32'h2);
			node.send_bit(lo[i] * 4, 70 * 4);
			rd(`OFS_INT_STATUS);
			err_exp = exp_err(lo[i], cf[i]);
			cmp_word(d & 32'h2, {30'h0, err_exp, 1'b0});
			cmp_word({31'h0, irq}, {31'h0, err_exp});
			wr(`OFS_INT_STATUS, 32'h7);
		end
		wr(`OFS_INT_MASK, 32'h0);
		node.send_bit(8 * 4, 70 * 4);
		cmp_word({31'h0, irq}, 32'h0);
		wr(`OFS_INT_MASK, 32'h2);
		cmp_word({31'h0, irq}, 32'h1);
		wr(`OFS_INT_STATUS, 32'h2);
		cmp_word({31'h0, irq}, 32'h0);
		$display("test waveform done");
		wr(`OFS_RX_CTRL, 32'h0);
		v = (rnd() & 32'hff) | 32'h100;
		wr(`OFS_TX_BUFFER, v);
		wr(`OFS_TX_TIMING, 32'h0);
		lows.delete();
		wr(`OFS_TX_ENABLE, 32'h1);
		wait_busy(1'b1);
		cmp_word(lows.size(), 32'h0);
		wait_busy(1'b0);
		cmp_word(d, 32'h0);
		rd(`OFS_INT_STATUS);
		cmp_word(d, 32'h1);
		got = 9'h0;
		for (int k = 1; k < 10; k++)
			got = {got[7:0], lows[k] < 35 * 4};
		// start bit, eight data bits, end-of-message bit, ack slot
		cmp_word(lows.size(), 32'hb);
		cmp_word({23'h0, got}, {23'h0, v[7:0], v[8]});
		$display("test transmit done");
		wr(`OFS_INT_STATUS, 32'h7);
		lows.delete();
		wr(`OFS_TX_ENABLE, 32'h1);
		while (lows.size() == 0)
			@(posedge aclk);
		node.send_bit(5 * 4, 0);
		wait_busy(1'b0);
		cmp_word(d, 32'h0);
		rd(`OFS_INT_STATUS);
		cmp_word(d & 32'h4, 32'h4);
		$display("test error done");
		wr(`OFS_INT_STATUS, 32'h7);
		wr(`OFS_TX_ENABLE, 32'h1);
		wait_busy(1'b1);
		wr(`OFS_TX_ENABLE, 32'h0);
		wait_busy(1'b0);
		rd(`OFS_INT_STATUS);
		cmp_word(d, 32'h0);
		$display("test stop done");
		test_done();
	end
endmodule : test_cec_ctrl

// ### verilog/cec_ctrl.sv
// control bus transmitter and receive waveform checker with axi4-lite regs
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "cec_cfg.svh"
module cec_ctrl #(
	parameter int SAMPLE_DIV = `SAMPLE_CYC
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// shared bus line, open drain
	input  wire logic        cec_in,
	output logic             cec_out,
	output logic             cec_oe,
	// interrupt
	output logic             irq
);
	if (SAMPLE_DIV < 2 || SAMPLE_DIV > 65535) begin : g_div_check
		$error("SAMPLE_DIV out of range");
	end

	//------------------------------------------------------------
	// sampling clock enable
	//------------------------------------------------------------
	logic [15:0] div_ff;
	wire         tick = (div_ff == 16'(SAMPLE_DIV - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn || tick)
			div_ff <= 16'h0000;
		else
			div_ff <= div_ff + 16'h0001;
	end

	//------------------------------------------------------------
	// register bus
	//------------------------------------------------------------
	logic        aw_ff, w_ff, bvalid_ff, rvalid_ff;
	logic [7:0]  awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [3:0]  wstrb_ff;
	logic [1:0]  bresp_ff, rresp_ff;
	logic [31:0] rx_ctrl_ff, tx_buf_ff, tx_tim_ff, int_stat_ff, int_mask_ff;
	logic        go_ff, busy_ff;

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] be,
			input logic [31:0] msk);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r & msk;
	endfunction : merge

	function automatic logic map_hit(input logic [7:0] a);
		return a == `OFS_RX_CTRL || a == `OFS_TX_ENABLE ||
			a == `OFS_TX_BUFFER || a == `OFS_TX_TIMING ||
			a == `OFS_INT_STATUS || a == `OFS_INT_MASK;
	endfunction : map_hit

	assign s_axi_awready = !aw_ff && !bvalid_ff;
	assign s_axi_wready  = !w_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	wire do_wr  = aw_ff && w_ff && !bvalid_ff;
	wire wr_rx  = do_wr && awaddr_ff == `OFS_RX_CTRL;
	wire wr_te  = do_wr && awaddr_ff == `OFS_TX_ENABLE && wstrb_ff[0];
	wire wr_tb  = do_wr && awaddr_ff == `OFS_TX_BUFFER;
	wire wr_tt  = do_wr && awaddr_ff == `OFS_TX_TIMING;
	wire wr_is  = do_wr && awaddr_ff == `OFS_INT_STATUS;
	wire wr_im  = do_wr && awaddr_ff == `OFS_INT_MASK;
	wire do_rd  = s_axi_arvalid && s_axi_arready;

	wire [31:0] te_rd = {30'h0, busy_ff, 1'b0};
	wire [31:0] rd_mux =
		(s_axi_araddr == `OFS_RX_CTRL)    ? rx_ctrl_ff :
		(s_axi_araddr == `OFS_TX_ENABLE)  ? te_rd :
		(s_axi_araddr == `OFS_TX_BUFFER)  ? tx_buf_ff :
		(s_axi_araddr == `OFS_TX_TIMING)  ? tx_tim_ff :
		(s_axi_araddr == `OFS_INT_STATUS) ? int_stat_ff :
		(s_axi_araddr == `OFS_INT_MASK)   ? int_mask_ff : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff     <= 1'b0;
			w_ff      <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff  <= 32'h0000_0000;
			wstrb_ff  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ff     <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end else if (do_wr)
				aw_ff <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) begin
				w_ff     <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end else if (do_wr)
				w_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= 2'h0;
		end else if (do_wr) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= map_hit(awaddr_ff) ? 2'h0 : 2'h2;
		end else if (s_axi_bready)
			bvalid_ff <= 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= 2'h0;
		end else if (do_rd) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_mux;
			rresp_ff  <= map_hit(s_axi_araddr) ? 2'h0 : 2'h2;
		end else if (s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_ctrl_ff  <= 32'h0000_0000;
			tx_buf_ff   <= 32'h0000_0000;
			tx_tim_ff   <= 32'h0000_0000;
			int_mask_ff <= 32'h0000_0000;
		end else begin
			if (wr_rx)
				rx_ctrl_ff <= merge(rx_ctrl_ff, wdata_ff, wstrb_ff, `RXC_MASK);
			if (wr_tb)
				tx_buf_ff <= merge(tx_buf_ff, wdata_ff, wstrb_ff, `TXB_MASK);
			if (wr_tt)
				tx_tim_ff <= merge(tx_tim_ff, wdata_ff, wstrb_ff, `TXT_MASK);
			if (wr_im)
				int_mask_ff <= merge(int_mask_ff, wdata_ff, wstrb_ff, `IRQ_MASK);
		end
	end

	//------------------------------------------------------------
	// receive waveform checker
	//------------------------------------------------------------
	logic       line_ff, rx_act_ff;
	logic [7:0] rcnt_ff;
	wire rx_en  = rx_ctrl_ff[`RXC_RX_EN];
	wire wav_en = rx_ctrl_ff[`RXC_WAV_EN];
	wire fall   = line_ff && !cec_in;
	wire rise   = !line_ff && cec_in;
	// limits in sampling periods from the bit's falling edge
	wire [7:0] lim_late = `BASE_LATE_ZERO +
		8'(rx_ctrl_ff[`RXC_WAV3_LSB +: 3]);
	wire [7:0] lim_one  = `BASE_ONE_END +
		8'(rx_ctrl_ff[`RXC_WAV1_LSB +: 3]);
	wire [7:0] lim_zero = `BASE_ZERO_START -
		8'(rx_ctrl_ff[`RXC_WAV2_LSB +: 3]);
	wire [7:0] lim_early = `BASE_EARLY_ONE -
		8'(rx_ctrl_ff[`RXC_WAV0_LSB +: 3]);
	wire rise_early = rise && rx_act_ff && rcnt_ff < lim_early;
	wire rise_gap   = rise && rx_act_ff && rcnt_ff > lim_one &&
		rcnt_ff < lim_zero;
	wire late_to    = rx_act_ff && tick && rcnt_ff == lim_late;
	wire wav_err    = rx_en && wav_en &&
		(rise_early || rise_gap || late_to);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_ff   <= 1'b1;
			rx_act_ff <= 1'b0;
			rcnt_ff   <= 8'h00;
		end else begin
			line_ff <= cec_in;
			if (!rx_en || rise || late_to)
				rx_act_ff <= 1'b0;
			else if (fall && !cec_oe)
				rx_act_ff <= 1'b1;
			if (fall)
				rcnt_ff <= 8'h00;
			else if (tick && rcnt_ff != 8'hff)
				rcnt_ff <= rcnt_ff + 8'h01;
		end
	end

	//------------------------------------------------------------
	// transmitter
	//------------------------------------------------------------
	cec_pkg::tx_state_t st_ff, nxt_st;
	logic [7:0] tcnt_ff;
	logic [3:0] bit_ff;
	logic [8:0] sh_ff;
	logic       drive_low_ff;

	wire [7:0] st_rise = `BASE_START_RISE - 8'(tx_tim_ff[`TXT_STRS_LSB +: 3]);
	wire [7:0] st_cyc  = `BASE_START_CYC - 8'(tx_tim_ff[`TXT_SPRD_LSB +: 3]);
	wire [7:0] d_trim  = 8'(tx_tim_ff[`TXT_DTRS_LSB +: 2]);
	wire [7:0] d_cyc   = `BASE_DATA_CYC - 8'(tx_tim_ff[`TXT_DPRD_LSB +: 4]);
	wire       cur_bit = (st_ff == cec_pkg::TX_ACK) ? 1'b1 : sh_ff[8];
	wire [7:0] d_rise  = (cur_bit ? `BASE_RISE_ONE : `BASE_RISE_ZERO) - d_trim;
	wire [7:0] free_cyc = 8'(tx_tim_ff[3:0]) + 8'h01;
	wire       cyc_end = tick && (
		(st_ff == cec_pkg::TX_START && tcnt_ff == st_cyc - 8'h01) ||
		((st_ff == cec_pkg::TX_DATA || st_ff == cec_pkg::TX_ACK) &&
			tcnt_ff == d_cyc - 8'h01));
	// another node pulling low while we release the line in a frame;
	// the ack slot is left out so that a follower may stretch it
	wire       in_frame = (st_ff == cec_pkg::TX_START) ||
		(st_ff == cec_pkg::TX_DATA);
	wire       tx_err  = tick && in_frame && !drive_low_ff && !cec_in;
	wire       tx_done = cyc_end && st_ff == cec_pkg::TX_ACK &&
		tx_buf_ff[`TXB_EOM];
	wire       stop_tx = wr_te && !wdata_ff[`TXE_GO];

	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			cec_pkg::TX_IDLE:  if (go_ff) nxt_st = cec_pkg::TX_FREE;
			cec_pkg::TX_FREE:  if (tick && tcnt_ff == free_cyc)
				nxt_st = cec_pkg::TX_START;
			cec_pkg::TX_START: if (cyc_end) nxt_st = cec_pkg::TX_DATA;
			cec_pkg::TX_DATA:  if (cyc_end && bit_ff == 4'h8)
				nxt_st = cec_pkg::TX_ACK;
			cec_pkg::TX_ACK:   if (cyc_end) nxt_st = cec_pkg::TX_IDLE;
		endcase
		if (tx_err || stop_tx)
			nxt_st = cec_pkg::TX_IDLE;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff        <= cec_pkg::TX_IDLE;
			tcnt_ff      <= 8'h00;
			bit_ff       <= 4'h0;
			sh_ff        <= 9'h000;
			drive_low_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			if (nxt_st != st_ff || cyc_end)
				tcnt_ff <= 8'h00;
			else if (tick)
				tcnt_ff <= tcnt_ff + 8'h01;
			if (st_ff == cec_pkg::TX_IDLE)
				sh_ff <= {tx_buf_ff[7:0], tx_buf_ff[`TXB_EOM]};
			else if (cyc_end && st_ff == cec_pkg::TX_DATA)
				sh_ff <= {sh_ff[7:0], 1'b0};
			if (st_ff != cec_pkg::TX_DATA)
				bit_ff <= 4'h0;
			else if (cyc_end)
				bit_ff <= bit_ff + 4'h1;
			unique case (st_ff)
				cec_pkg::TX_START: drive_low_ff <= tcnt_ff < st_rise;
				cec_pkg::TX_DATA,
				cec_pkg::TX_ACK:   drive_low_ff <= tcnt_ff < d_rise;
				default:           drive_low_ff <= 1'b0;
			endcase
		end
	end

	assign cec_out = 1'b0;
	assign cec_oe  = drive_low_ff;

	// transmit go and busy flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			go_ff   <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			if (wr_te)
				go_ff <= wdata_ff[`TXE_GO];
			else if (tx_done || tx_err)
				go_ff <= 1'b0;
			if (nxt_st == cec_pkg::TX_START && st_ff == cec_pkg::TX_FREE)
				busy_ff <= 1'b1;
			else if (nxt_st == cec_pkg::TX_IDLE)
				busy_ff <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// interrupts
	//------------------------------------------------------------
	wire [31:0] ev = {29'h0, tx_err, wav_err, tx_done};

	always_ff @(posedge aclk) begin
		if (!aresetn)
			int_stat_ff <= 32'h0000_0000;
		else if (wr_is)
			int_stat_ff <= (int_stat_ff & ~(wdata_ff & `IRQ_MASK)) | ev;
		else
			int_stat_ff <= int_stat_ff | ev;
	end

	assign irq = |(int_stat_ff & int_mask_ff);
endmodule : cec_ctrl
